// ### hw/dcsr_regs.sv
// control and status registers of the system-side line interface device
// assumes an apb master on clock, line-side status inputs synchronous to clock
//
// Contract
// - negative-ring status bit reads 1 while a negative ring is present.
// - positive-ring status bit reads 1 while a positive ring is present.
// - on-hook monitor bit enables low-power monitoring without going off-hook.
// - ring-detect flag set by ringing, cleared 5 s after last positive ring or off-hook.
// - full-wave option lets negative rings set ring-detect too.
// - off-hook bit 1 takes line side off-hook, 0 returns it on-hook.
// - line-side power-down bit keeps line side low power; resets to 1.
// - system power-down holds until a reset pulse; host supplies it.
// - high-speed bit selects 8 kHz or 16 kHz sample rate.
// - in high-speed mode frame stays 8 kHz, two samples in adjacent slots.
// - digital loopback returns receive highway data unchanged on transmit.
// - upper nibble of revision register holds line-side identifier.
// - lower nibble of revision register holds system-side revision.
// - frame-lock bit reads 1 when isolation link is locked.
// - loop current reads as 5-bit field, 3.3 mA per step.
// - loop current codes 00000 low, 00100 minimum, 11111 overload.
// - ring interrupt flag set on ringing, held until host writes 0.
// - frame-loss interrupt flag set whenever frame lock is missing.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module dcsr_regs #(
	parameter int RING_HOLD_CYCLES = dcsr_pkg::RING_HOLD_CYC
) (
	input  logic                         clock,
	input  logic                         rstn,
	input  dcsr_pkg::dcsr_apb_req_t      apb_req,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  dcsr_pkg::dcsr_line_status_t  line_status,
	input  logic                         highway_receive_in,
	input  logic                         codec_transmit_in,
	output logic                         highway_transmit_out,
	output logic                         offhook_command,
	output logic                         onhook_monitor_enable,
	output logic                         line_side_powerdown,
	output logic                         system_side_powerdown,
	output logic                         high_speed_sampling,
	output logic                         samples_per_frame_two
);

	logic [7:0] line_ctrl;
	logic [7:0] power_ctrl;
	logic [7:0] sample_ctrl;
	logic [7:0] loopback_ctrl;
	logic       full_wave_ring_option;
	logic       ring_interrupt_flag;
	logic       frame_loss_interrupt_flag;
	logic       ring_detect_flag;
	logic       ring_detect_prev;
	logic       offhook_pulse;
	logic       wr_access;
	logic       setup;
	logic [7:0] wr_index;
	logic [7:0] wr_byte;
	logic [7:0] next_read;
	logic       next_err;

	////////////////////////////////////////////////////////////////////////
	// address helpers

	// byte address to register index; misaligned addresses are unmapped
	function automatic logic [7:0] reg_index(input logic [7:0] addr);
		reg_index = {2'h0, addr[7:2]};
	endfunction : reg_index

	function automatic logic is_mapped(input logic [7:0] addr);
		logic [7:0] idx;
		idx = {2'h0, addr[7:2]};
		is_mapped = (addr[1:0] == 2'h0) && idx >= dcsr_pkg::IDX_RING_EVENTS
			&& idx <= dcsr_pkg::IDX_RING_OPTION;
	endfunction : is_mapped

	////////////////////////////////////////////////////////////////////////
	// apb phase decode; pready is raised by the setup edge so no wait states
	assign setup     = apb_req.psel & ~apb_req.penable;
	assign wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite & pready
		& is_mapped(apb_req.paddr);
	assign wr_index  = reg_index(apb_req.paddr);
	assign wr_byte   = apb_req.pwdata[7:0];
	// after system power-down only reset brings control writes back
	assign offhook_pulse = wr_access & ~system_side_powerdown
		& wr_index == dcsr_pkg::IDX_LINE_CTRL & wr_byte[dcsr_pkg::BIT_OFFHOOK];

	// read mux; status fields are live, reserved bits zero
	always_comb begin
		next_read = 8'h00;
		next_err  = ~is_mapped(apb_req.paddr);
		case (reg_index(apb_req.paddr))
			dcsr_pkg::IDX_RING_EVENTS: begin
				next_read[dcsr_pkg::BIT_RING_INT]       = ring_interrupt_flag;
				next_read[dcsr_pkg::BIT_FRAME_LOSS_INT] = frame_loss_interrupt_flag;
			end
			dcsr_pkg::IDX_LINE_CTRL: begin
				next_read[dcsr_pkg::BIT_RING_NEG]    = line_status.ring_neg;
				next_read[dcsr_pkg::BIT_RING_POS]    = line_status.ring_pos;
				next_read[dcsr_pkg::BIT_ONHOOK_MON]  = line_ctrl[dcsr_pkg::BIT_ONHOOK_MON];
				next_read[dcsr_pkg::BIT_RING_DETECT] = ring_detect_flag;
				next_read[dcsr_pkg::BIT_OFFHOOK]     = line_ctrl[dcsr_pkg::BIT_OFFHOOK];
			end
			dcsr_pkg::IDX_POWER_CTRL:  next_read = power_ctrl;
			dcsr_pkg::IDX_SAMPLE_CTRL: next_read = sample_ctrl;
			dcsr_pkg::IDX_LOOPBACK:    next_read = loopback_ctrl;
			dcsr_pkg::IDX_IDENTITY: begin
				next_read = {line_status.line_side_identifier,
					dcsr_pkg::SYSTEM_REVISION};
			end
			dcsr_pkg::IDX_LINE_STATUS: begin
				next_read[dcsr_pkg::BIT_FRAME_LOCK] = line_status.frame_lock;
				next_read[4:0] = line_status.loop_current_level;
			end
			dcsr_pkg::IDX_RING_OPTION: begin
				next_read[dcsr_pkg::BIT_FULL_WAVE] = full_wave_ring_option;
			end
			default: next_read = 8'h00;
		endcase
		// refused addresses return zero so a misaligned read leaks no register
		if (next_err) next_read = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// bus answer, captured at the setup edge
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pready  <= 1'b1;
			prdata  <= {24'h00_0000, next_read};
			pslverr <= next_err;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers; status and reserved bits are masked off on write
	always_ff @(posedge clock) begin
		if (!rstn) begin
			line_ctrl <= dcsr_pkg::RST_LINE_CTRL;
		end else if (wr_access && !system_side_powerdown
			&& wr_index == dcsr_pkg::IDX_LINE_CTRL) begin
			line_ctrl <= 8'h00;
			line_ctrl[dcsr_pkg::BIT_ONHOOK_MON] <= wr_byte[dcsr_pkg::BIT_ONHOOK_MON];
			line_ctrl[dcsr_pkg::BIT_OFFHOOK]    <= wr_byte[dcsr_pkg::BIT_OFFHOOK];
		end
	end

	// power-down bits; system power-down is sticky until reset
	always_ff @(posedge clock) begin
		if (!rstn) begin
			power_ctrl <= dcsr_pkg::RST_POWER_CTRL;
		end else if (wr_access && !system_side_powerdown
			&& wr_index == dcsr_pkg::IDX_POWER_CTRL) begin
			power_ctrl <= 8'h00;
			power_ctrl[dcsr_pkg::BIT_LINE_PDOWN] <= wr_byte[dcsr_pkg::BIT_LINE_PDOWN];
			power_ctrl[dcsr_pkg::BIT_SYS_PDOWN]  <= wr_byte[dcsr_pkg::BIT_SYS_PDOWN];
		end
	end

	// sample rate, loopback and ring option
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sample_ctrl           <= dcsr_pkg::RST_SAMPLE_CTRL;
			loopback_ctrl         <= dcsr_pkg::RST_LOOPBACK;
			full_wave_ring_option <= 1'b0;
		end else if (wr_access && !system_side_powerdown) begin
			if (wr_index == dcsr_pkg::IDX_SAMPLE_CTRL) begin
				sample_ctrl <= 8'h00;
				sample_ctrl[dcsr_pkg::BIT_HIGH_SPEED] <= wr_byte[dcsr_pkg::BIT_HIGH_SPEED];
			end
			if (wr_index == dcsr_pkg::IDX_LOOPBACK) begin
				loopback_ctrl <= 8'h00;
				loopback_ctrl[dcsr_pkg::BIT_LOOPBACK] <= wr_byte[dcsr_pkg::BIT_LOOPBACK];
			end
			if (wr_index == dcsr_pkg::IDX_RING_OPTION) begin
				full_wave_ring_option <= wr_byte[dcsr_pkg::BIT_FULL_WAVE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ring detect hold timer
	dcsr_ring_timer #(
		.HOLD_CYCLES (RING_HOLD_CYCLES)
	) u_ring_timer (
		.clock            (clock),
		.rstn             (rstn),
		.ring_pos         (line_status.ring_pos),
		.ring_neg         (line_status.ring_neg),
		.full_wave        (full_wave_ring_option),
		.offhook_pulse    (offhook_pulse),
		.ring_detect_flag (ring_detect_flag)
	);

	// sticky event flags; hardware set wins over a host clear
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ring_detect_prev          <= 1'b0;
			ring_interrupt_flag       <= 1'b0;
			frame_loss_interrupt_flag <= 1'b0;
		end else begin
			ring_detect_prev <= ring_detect_flag;
			if (ring_detect_flag && !ring_detect_prev) begin
				ring_interrupt_flag <= 1'b1;
			end else if (wr_access && wr_index == dcsr_pkg::IDX_RING_EVENTS
				&& !wr_byte[dcsr_pkg::BIT_RING_INT]) begin
				ring_interrupt_flag <= 1'b0;
			end
			if (!line_status.frame_lock) begin
				frame_loss_interrupt_flag <= 1'b1;
			end else if (wr_access && wr_index == dcsr_pkg::IDX_RING_EVENTS
				&& !wr_byte[dcsr_pkg::BIT_FRAME_LOSS_INT]) begin
				frame_loss_interrupt_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control outputs to the line side and codec, all registered
	always_ff @(posedge clock) begin
		if (!rstn) begin
			offhook_command       <= 1'b0;
			onhook_monitor_enable <= 1'b0;
			line_side_powerdown   <= 1'b1;
			system_side_powerdown <= 1'b0;
			high_speed_sampling   <= 1'b0;
			samples_per_frame_two <= 1'b0;
		end else begin
			offhook_command       <= line_ctrl[dcsr_pkg::BIT_OFFHOOK];
			onhook_monitor_enable <= line_ctrl[dcsr_pkg::BIT_ONHOOK_MON];
			line_side_powerdown   <= power_ctrl[dcsr_pkg::BIT_LINE_PDOWN];
			// once set, nothing but reset clears it
			system_side_powerdown <= system_side_powerdown
				| power_ctrl[dcsr_pkg::BIT_SYS_PDOWN];
			high_speed_sampling   <= sample_ctrl[dcsr_pkg::BIT_HIGH_SPEED];
			// frame rate stays 8 kHz, so 16 kHz needs two adjacent slots
			samples_per_frame_two <= sample_ctrl[dcsr_pkg::BIT_HIGH_SPEED];
		end
	end

	// loopback: raw receive bit goes out on transmit unchanged, one clock later
	always_ff @(posedge clock) begin
		if (!rstn) begin
			highway_transmit_out <= 1'b0;
		end else if (loopback_ctrl[dcsr_pkg::BIT_LOOPBACK]) begin
			highway_transmit_out <= highway_receive_in;
		end else begin
			highway_transmit_out <= codec_transmit_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_setup_at(logic [7:0] idx);
		apb_req.psel && !apb_req.penable && !apb_req.pwrite
			&& apb_req.paddr == {idx[5:0], 2'b00};
	endsequence

	sequence s_write_at(logic [7:0] idx);
		wr_access && wr_index == idx && !system_side_powerdown;
	endsequence

	property p_ring_neg;
		s_setup_at(dcsr_pkg::IDX_LINE_CTRL)
			|=> prdata[dcsr_pkg::BIT_RING_NEG] == $past(line_status.ring_neg);
	endproperty
	a_ring_neg: assert property (p_ring_neg) else $error("negative ring bit wrong");

	property p_ring_pos;
		s_setup_at(dcsr_pkg::IDX_LINE_CTRL)
			|=> prdata[dcsr_pkg::BIT_RING_POS] == $past(line_status.ring_pos) && pready;
	endproperty
	a_ring_pos: assert property (p_ring_pos) else $error("positive ring bit wrong");

	property p_monitor;
		s_write_at(dcsr_pkg::IDX_LINE_CTRL)
			|=> ##1 onhook_monitor_enable == $past(wr_byte[dcsr_pkg::BIT_ONHOOK_MON], 2);
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor output not updated");

	property p_offhook_clears_ring;
		offhook_pulse && !line_status.ring_pos && !line_status.ring_neg
			|=> !ring_detect_flag;
	endproperty
	a_offhook_clears_ring: assert property (p_offhook_clears_ring)
		else $error("ring detect survived off-hook");

	property p_half_wave;
		!full_wave_ring_option && !line_status.ring_pos && !ring_detect_flag
			|=> !ring_detect_flag;
	endproperty
	a_half_wave: assert property (p_half_wave) else $error("negative ring set ring detect");

	property p_offhook;
		s_write_at(dcsr_pkg::IDX_LINE_CTRL)
			|=> ##1 offhook_command == $past(wr_byte[dcsr_pkg::BIT_OFFHOOK], 2);
	endproperty
	a_offhook: assert property (p_offhook) else $error("off-hook output not updated");

	property p_line_pdown_reset;
		@(posedge clock) disable iff (1'b0) !rstn |=> line_side_powerdown;
	endproperty
	a_line_pdown_reset: assert property (p_line_pdown_reset)
		else $error("line side not powered down at reset");

	property p_sys_pdown_sticky;
		system_side_powerdown |=> system_side_powerdown [*4];
	endproperty
	a_sys_pdown_sticky: assert property (p_sys_pdown_sticky)
		else $error("system power-down left without reset");

	property p_loopback;
		loopback_ctrl[dcsr_pkg::BIT_LOOPBACK]
			|=> highway_transmit_out == $past(highway_receive_in);
	endproperty
	a_loopback: assert property (p_loopback) else $error("loopback data altered");

	property p_frame_lock;
		s_setup_at(dcsr_pkg::IDX_LINE_STATUS)
			|=> prdata[7:0] == {1'b0, $past(line_status.frame_lock), 1'b0,
				$past(line_status.loop_current_level)};
	endproperty
	a_frame_lock: assert property (p_frame_lock) else $error("line status read wrong");

	property p_ring_int_sticky;
		ring_interrupt_flag && !(wr_access && wr_index == dcsr_pkg::IDX_RING_EVENTS)
			|=> ring_interrupt_flag;
	endproperty
	a_ring_int_sticky: assert property (p_ring_int_sticky)
		else $error("ring interrupt flag dropped");

	property p_frame_loss;
		!line_status.frame_lock |=> frame_loss_interrupt_flag;
	endproperty
	a_frame_loss: assert property (p_frame_loss) else $error("frame loss flag not set");

	property p_reserved;
		s_setup_at(dcsr_pkg::IDX_RESERVED_A) or s_setup_at(dcsr_pkg::IDX_RESERVED_B)
			|=> prdata == 32'h0000_0000 && !pslverr;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved register not zero");

endmodule : dcsr_regs

// ### hw/dcsr_pkg.sv
// control and status register group: shared constants and carrier types
// assumes a single 100 MHz clock and an APB register port
package dcsr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_RING_EVENTS  = 8'h04;
	localparam logic [7:0] IDX_LINE_CTRL    = 8'h05;
	localparam logic [7:0] IDX_POWER_CTRL   = 8'h06;
	localparam logic [7:0] IDX_SAMPLE_CTRL  = 8'h07;
	localparam logic [7:0] IDX_RESERVED_A   = 8'h08;
	localparam logic [7:0] IDX_RESERVED_B   = 8'h09;
	localparam logic [7:0] IDX_LOOPBACK     = 8'h0a;
	localparam logic [7:0] IDX_IDENTITY     = 8'h0b;
	localparam logic [7:0] IDX_LINE_STATUS  = 8'h0c;
	localparam logic [7:0] IDX_RING_OPTION  = 8'h0d;

	// field positions
	localparam int BIT_RING_NEG       = 6;
	localparam int BIT_RING_POS       = 5;
	localparam int BIT_ONHOOK_MON     = 3;
	localparam int BIT_RING_DETECT    = 2;
	localparam int BIT_OFFHOOK        = 0;
	localparam int BIT_LINE_PDOWN     = 4;
	localparam int BIT_SYS_PDOWN      = 3;
	localparam int BIT_HIGH_SPEED     = 3;
	localparam int BIT_LOOPBACK       = 0;
	localparam int BIT_FRAME_LOCK     = 6;
	localparam int BIT_RING_INT       = 7;
	localparam int BIT_FRAME_LOSS_INT = 5;
	localparam int BIT_FULL_WAVE      = 0;

	// reset values
	localparam logic [7:0] RST_LINE_CTRL   = 8'h00;
	localparam logic [7:0] RST_POWER_CTRL  = 8'h10;
	localparam logic [7:0] RST_SAMPLE_CTRL = 8'h00;
	localparam logic [7:0] RST_LOOPBACK    = 8'h00;

	// arbitrary system-side revision value
	localparam logic [3:0] SYSTEM_REVISION = 4'h2;

	// ring detect hold time
	localparam longint RING_HOLD_MS  = 5000;
	localparam longint CLOCK_KHZ     = 100000;
	localparam int     RING_HOLD_CYC = int'(RING_HOLD_MS * CLOCK_KHZ);
	localparam int     CNT_W         = 32;

	// live status reported by the line-side device
	typedef struct packed {
		logic       ring_pos;
		logic       ring_neg;
		logic       frame_lock;
		logic [4:0] loop_current_level;
		logic [3:0] line_side_identifier;
	} dcsr_line_status_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dcsr_apb_req_t;

endpackage : dcsr_pkg

// ### hw/dcsr_ring_timer.sv
// ring detect hold timer: flag set by ringing, cleared after hold time or off-hook
// assumes ring inputs synchronous to clock
`timescale 1ns/10ps
module dcsr_ring_timer #(
	parameter int HOLD_CYCLES = dcsr_pkg::RING_HOLD_CYC
) (
	input  logic clock,
	input  logic rstn,
	input  logic ring_pos,
	input  logic ring_neg,
	input  logic full_wave,
	input  logic offhook_pulse,
	output logic ring_detect_flag
);

	logic [dcsr_pkg::CNT_W-1:0] hold_count;
	logic                       ring_set;

	// negative rings count only with the full-wave option
	assign ring_set = ring_pos | (full_wave & ring_neg);

	////////////////////////////////////////////////////////////////////////
	// hold counter reloads on every positive ring; a full-wave negative ring loads it only when it is at zero
	always_ff @(posedge clock) begin
		if (!rstn) begin
			hold_count <= '0;
		end else if (ring_pos) begin
			hold_count <= dcsr_pkg::CNT_W'(HOLD_CYCLES);
		end else if (ring_set && hold_count == '0) begin
			hold_count <= dcsr_pkg::CNT_W'(HOLD_CYCLES);
		end else if (offhook_pulse) begin
			hold_count <= '0;
		end else if (hold_count != '0) begin
			hold_count <= hold_count - 1'b1;
		end
	end

	// set wins over off-hook and timeout clear
	always_ff @(posedge clock) begin
		if (!rstn) begin
			ring_detect_flag <= 1'b0;
		end else if (ring_set) begin
			ring_detect_flag <= 1'b1;
		end else if (offhook_pulse || hold_count == dcsr_pkg::CNT_W'(1)) begin
			ring_detect_flag <= 1'b0;
		end
	end

endmodule : dcsr_ring_timer

// ### tb/dcsr_line_model.sv
// behavioural line-side device across the isolation link
// assumes the bench sets line conditions through the *_req inputs
`timescale 1ns/10ps
module dcsr_line_model #(
	parameter logic [3:0] LINE_ID = 4'h6 // arbitrary value
) (
	input  logic                        ring_pos_req,
	input  logic                        ring_neg_req,
	input  logic                        link_ok_req,
	input  logic [4:0]                  level_req,
	input  logic                        offhook_command,
	input  logic                        line_side_powerdown,
	output dcsr_pkg::dcsr_line_status_t line_status
);
	////////////////////////////////////////////////////////////////////////
	// a powered-down line side senses nothing and leaves the link unlocked,
	// so the host sees no ring and no loop current until it powers it up
	always_comb begin
		line_status.ring_pos = ring_pos_req & ~line_side_powerdown;
		line_status.ring_neg = ring_neg_req & ~line_side_powerdown;
		line_status.frame_lock = link_ok_req & ~line_side_powerdown;
		line_status.loop_current_level = 5'h00;
		if (offhook_command && !line_side_powerdown) begin
			line_status.loop_current_level = level_req;
		end
		line_status.line_side_identifier = LINE_ID;
	end
endmodule : dcsr_line_model

// ### tb/tb_top.sv
// self-checking bench for the control and status register group
// assumes the apb slave answers in its own time and status inputs are levels
`timescale 1ns/10ps
module tb_top;
	localparam int         HOLD    = 20;
	localparam logic [3:0] LINE_ID = 4'h6; // arbitrary value
	logic                        clock;
	logic                        rstn;
	dcsr_pkg::dcsr_apb_req_t     req;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	dcsr_pkg::dcsr_line_status_t line_status;
	logic                        hw_rx;
	logic                        codec_tx;
	logic                        hw_tx;
	logic                        last_rx;
	logic                        last_tx;
	logic                        chk_hw;
	logic                        lb_exp;
	logic [5:0]                  outs_now;
	logic                        ring_pos_req;
	logic                        ring_neg_req;
	logic                        link_ok_req;
	logic [4:0]                  level_req;
	logic [4:0]                  lvl;
	logic                        lock;
	logic [31:0]                 rd;
	logic                        err;
	integer                      seed;
	integer                      n_errors;
	integer                      n_compared;
	integer                      k;

	dcsr_regs #(.RING_HOLD_CYCLES(HOLD)) dut (
		.clock(clock), .rstn(rstn), .apb_req(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line_status(line_status), .highway_receive_in(hw_rx),
		.codec_transmit_in(codec_tx), .highway_transmit_out(hw_tx),
		.offhook_command(outs_now[5]), .onhook_monitor_enable(outs_now[4]),
		.line_side_powerdown(outs_now[3]), .system_side_powerdown(outs_now[2]),
		.high_speed_sampling(outs_now[1]), .samples_per_frame_two(outs_now[0]));

	dcsr_line_model #(.LINE_ID(LINE_ID)) line_side (
		.ring_pos_req(ring_pos_req), .ring_neg_req(ring_neg_req), .link_ok_req(link_ok_req),
		.level_req(level_req), .offhook_command(outs_now[5]),
		.line_side_powerdown(outs_now[3]), .line_status(line_status));

	////////////////////////////////////////////////////////////////////////
	// free-running clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task results;
		if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
		int i;
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {24'h0, wd}};
		@(posedge clock);
		req.penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			$display("[ERR] %0t no pready", $time);
			results();
		end
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {idx[5:0], 2'b00}, d);
		chk({31'h0, err}, 32'h0);
	endtask : wr

	task rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, {idx[5:0], 2'b00}, 8'h00);
		chk(rd, {24'h0, exp});
		chk({31'h0, err}, 32'h0);
	endtask : rdc

	// refused address: error flag and zero data
	task bad(input logic [7:0] addr);
		apb(1'b0, addr, 8'h00);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask : bad

	// outputs settle one cycle after the register itself
	task outs(input logic [5:0] exp);
		repeat (2) @(posedge clock);
		chk({26'h0, outs_now}, {26'h0, exp});
	endtask : outs

	task hw_window(input logic lb);
		// let the loopback select written at this edge reach the output flop
		@(posedge clock);
		lb_exp <= lb;
		chk_hw <= 1'b1;
		repeat (16) @(posedge clock);
		chk_hw <= 1'b0;
	endtask : hw_window

	////////////////////////////////////////////////////////////////////////
	// random highway bits; the checker compares against last cycle's input
	always @(posedge clock) begin
		last_rx <= hw_rx;
		last_tx <= codec_tx;
		hw_rx <= 1'($random(seed));
		codec_tx <= 1'($random(seed));
	end

	always @(negedge clock) begin
		if (chk_hw === 1'b1) chk({31'h0, hw_tx}, {31'h0, lb_exp ? last_rx : last_tx});
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 32'h40fab4ee;
		n_errors = 0;
		n_compared = 0;
		req = '0;
		rstn = 1'b0;
		chk_hw = 1'b0;
		lb_exp = 1'b0;
		ring_pos_req = 1'b0;
		ring_neg_req = 1'b0;
		link_ok_req = 1'b1;
		level_req = 5'h04;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		outs(6'b001000);
		rdc(dcsr_pkg::IDX_POWER_CTRL, 8'h10);
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h00);
		rdc(dcsr_pkg::IDX_RESERVED_A, 8'h00);
		rdc(dcsr_pkg::IDX_LINE_STATUS, 8'h00);
		rdc(dcsr_pkg::IDX_RING_EVENTS, 8'h20);
		// no clock generator in this block, so it counts as programmed
		wr(dcsr_pkg::IDX_POWER_CTRL, 8'h00);
		outs(6'b000000);
		wr(dcsr_pkg::IDX_RING_EVENTS, 8'h00);
		rdc(dcsr_pkg::IDX_RING_EVENTS, 8'h00);
		wr(dcsr_pkg::IDX_LINE_CTRL, 8'hff);
		outs(6'b110000);
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h09);
		// status codes: the three fixed ones first, then random
		for (k = 0; k < 12; k++) begin
			lvl = (k == 0) ? 5'h00 : (k == 1) ? 5'h04 : (k == 2) ? 5'h1f : 5'($random(seed));
			lock = (k == 0) ? 1'b0 : 1'($random(seed));
			@(posedge clock);
			level_req <= lvl;
			link_ok_req <= lock;
			if (k == 5) wr(dcsr_pkg::IDX_LINE_STATUS, 8'($random(seed)));
			rdc(dcsr_pkg::IDX_LINE_STATUS, {1'b0, lock, 1'b0, lvl});
		end
		link_ok_req <= 1'b1;
		rdc(dcsr_pkg::IDX_IDENTITY, {LINE_ID, dcsr_pkg::SYSTEM_REVISION});
		wr(dcsr_pkg::IDX_IDENTITY, 8'h00);
		rdc(dcsr_pkg::IDX_IDENTITY, {LINE_ID, dcsr_pkg::SYSTEM_REVISION});
		wr(dcsr_pkg::IDX_SAMPLE_CTRL, 8'hff);
		outs(6'b110011);
		rdc(dcsr_pkg::IDX_SAMPLE_CTRL, 8'h08);
		wr(dcsr_pkg::IDX_SAMPLE_CTRL, 8'h00);
		outs(6'b110000);
		hw_window(1'b0);
		wr(dcsr_pkg::IDX_LOOPBACK, 8'hff);
		rdc(dcsr_pkg::IDX_LOOPBACK, 8'h01);
		hw_window(1'b1);
		wr(dcsr_pkg::IDX_LOOPBACK, 8'h00);
		hw_window(1'b0);
		// half-wave rings: only the positive one arms ring detect
		wr(dcsr_pkg::IDX_LINE_CTRL, 8'h00);
		wr(dcsr_pkg::IDX_RING_EVENTS, 8'h00);
		ring_neg_req <= 1'b1;
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h40);
		ring_neg_req <= 1'b0;
		ring_pos_req <= 1'b1;
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h24);
		ring_pos_req <= 1'b0;
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h04);
		wr(dcsr_pkg::IDX_RING_EVENTS, 8'hff);
		rdc(dcsr_pkg::IDX_RING_EVENTS, 8'h80);
		repeat (HOLD + 4) @(posedge clock);
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h00);
		rdc(dcsr_pkg::IDX_RING_EVENTS, 8'h80);
		wr(dcsr_pkg::IDX_RING_EVENTS, 8'h00);
		rdc(dcsr_pkg::IDX_RING_EVENTS, 8'h00);
		// full-wave option lets a negative ring through
		wr(dcsr_pkg::IDX_RING_OPTION, 8'h01);
		ring_neg_req <= 1'b1;
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h44);
		ring_neg_req <= 1'b0;
		ring_pos_req <= 1'b1;
		@(posedge clock);
		ring_pos_req <= 1'b0;
		wr(dcsr_pkg::IDX_LINE_CTRL, 8'h01);
		rdc(dcsr_pkg::IDX_LINE_CTRL, 8'h01);
		bad(8'h38);
		bad(8'h15);
		apb(1'b1, {dcsr_pkg::IDX_RESERVED_B[5:0], 2'b00}, 8'hff);
		rdc(dcsr_pkg::IDX_RESERVED_B, 8'h00);
		// system power-down sticks until the reset pulse
		wr(dcsr_pkg::IDX_POWER_CTRL, 8'h08);
		outs(6'b100100);
		wr(dcsr_pkg::IDX_POWER_CTRL, 8'h00);
		wr(dcsr_pkg::IDX_LINE_CTRL, 8'h00);
		outs(6'b100100);
		rstn <= 1'b0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		outs(6'b001000);
		results();
	end
endmodule : tb_top
